// ### design/sysid_frame_builder.sv
// Station identification parameter list store and identification frame builder.
//
// Behaviour
// - Software kind low byte drives program request.
// - Message type 260h, read-only.
// - Code byte 7, upper byte zero.
// - Unsolicited frame carries receipt number zero.
// - Reply copies request receipt, host sees zero.
// - Protocol version kind is 1.
// - Version size 3 low, number 3 high.
// - Both change level bytes are zero.
// - Function kind 2, function size 2.
// - Function setting one 15h or 5 by switch.
// - Function setting two zero, low byte.
// - Address kind bytes 7 then 0.
// - Address size 6 in high byte.
// - Station address as three words, low first.
// - Device kind 64h, read-only.
// - Device size 1 in low byte.
// - Fixed device code in high byte.
// - Up to 146 extra bytes follow fixed fields.
// - Six undefined words carry no function.
// - Opcode 22 reads list, 23 writes it.
// - Length over 100 words aborts with error.
`default_nettype none
module sysid_frame_builder #(
  parameter logic [47:0] STATION_ADDR = 48'h0000_0000_0000,
  // Arbitrary neutral device code value.
  parameter logic [7:0]  DEVICE_CODE  = 8'h5A
) (
  input  wire  logic        I_CLOCK,
  input  wire  logic        I_SRST,
  input  wire  logic        I_CMD_VALID,
  input  wire  logic [7:0]  I_CMD_OPCODE,
  input  wire  logic [15:0] I_LIST_WORD_COUNT,
  output logic              O_CMD_BUSY,
  output logic              O_CMD_DONE,
  output logic              O_CMD_ERROR,
  input  wire  logic        I_WR_VALID,
  input  wire  logic [15:0] I_WR_WORD,
  output logic              O_RD_VALID,
  output logic [15:0]       O_RD_WORD,
  input  wire  logic        I_REMOTE_BOOT_SW,
  input  wire  logic        I_BOOT_CMD,
  output logic              O_PROG_REQ,
  output logic [7:0]        O_REQUESTED_SOFTWARE_KIND,
  input  wire  logic        I_FRAME_START,
  input  wire  logic        I_FRAME_IS_REPLY,
  input  wire  logic [15:0] I_REQ_RECEIPT_NUMBER,
  output logic              O_FRAME_BUSY,
  output logic              O_TX_VALID,
  output logic [7:0]        O_TX_DATA,
  output logic              O_TX_LAST,
  input  wire  logic        I_TX_READY
);

  initial begin
    if (STATION_ADDR[40] != 1'b0) begin
      $error("Station address must be an individual address.");
    end
  end

  typedef enum logic [1:0] {CMD_IDLE, CMD_READ, CMD_WRITE} cmd_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_FIXED, TX_EXTRA} tx_state_t;

  cmd_state_t  cmd_state;
  tx_state_t   tx_state;
  logic [7:0]  requested_software_kind;
  logic [15:0] char_count_field;
  logic [15:0] extra_info_block [sysid_pkg::EXTRA_WORDS];
  logic [15:0] list_word_count;
  logic [6:0]  cnt;
  logic [2:0]  sw_sync;
  logic        remote_boot;
  logic [15:0] receipt_number;
  logic [7:0]  tx_pos;
  logic [7:0]  tx_total;
  logic [6:0]  tx_idx;
  logic [15:0] tx_word;
  logic [15:0] host_word;
  logic [7:0]  extra_bytes;
  logic        tx_take;

  sysid_rom_if rom_if ();

  sysid_fixed_rom #(
    .STATION_ADDR (STATION_ADDR),
    .DEVICE_CODE  (DEVICE_CODE)
  ) u_rom (
    .rom (rom_if.rom)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Boot select switch input.

  // The switch is a pin; a new level counts only once two late stages agree.
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      sw_sync <= 3'h0;
    end else begin
      sw_sync <= {sw_sync[1:0], I_REMOTE_BOOT_SW};
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      remote_boot <= 1'b0;
    end else if (sw_sync[1] == sw_sync[2]) begin
      remote_boot <= sw_sync[2];
    end
  end

  assign rom_if.remote_boot = remote_boot;

  ////////////////////////////////////////////////////////////////////////////////
  // Word lookup shared by host reads and frame building.

  function automatic logic [15:0] list_word(input logic [6:0] idx, input logic [15:0] fixed);
    logic [15:0] w;
    w = fixed;
    if (idx == sysid_pkg::IDX_SOFT_KIND) begin
      w = {8'h00, requested_software_kind};
    end else if (idx == sysid_pkg::IDX_CHAR_COUNT) begin
      w = char_count_field;
    end else if (idx >= sysid_pkg::IDX_EXTRA_BASE) begin
      w = extra_info_block[idx - sysid_pkg::IDX_EXTRA_BASE];
    end
    return w;
  endfunction : list_word

  assign rom_if.host_idx = cnt;
  // The lookup reads stored fields, so it must wake on them and not only on its arguments.
  always_comb begin
    host_word = list_word(cnt, rom_if.host_word);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host command sequencing.

  assign O_CMD_BUSY = (cmd_state != CMD_IDLE);

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      cmd_state       <= CMD_IDLE;
      cnt             <= 7'h00;
      list_word_count <= 16'h0000;
      O_CMD_DONE      <= 1'b0;
      O_CMD_ERROR     <= 1'b0;
    end else begin
      O_CMD_DONE  <= 1'b0;
      O_CMD_ERROR <= 1'b0;
      unique case (cmd_state)
        CMD_IDLE: begin
          cnt <= 7'h00;
          if (I_CMD_VALID) begin
            list_word_count <= I_LIST_WORD_COUNT;
            if ((I_CMD_OPCODE != sysid_pkg::OP_READ_LIST) && (I_CMD_OPCODE != sysid_pkg::OP_WRITE_LIST)) begin
              O_CMD_DONE  <= 1'b1;
              O_CMD_ERROR <= 1'b1;
            end else if (I_LIST_WORD_COUNT > sysid_pkg::LIST_MAX_WORDS) begin
              O_CMD_DONE  <= 1'b1;
              O_CMD_ERROR <= 1'b1;
            end else if (I_LIST_WORD_COUNT == 16'h0000) begin
              O_CMD_DONE <= 1'b1;
            end else if (I_CMD_OPCODE == sysid_pkg::OP_READ_LIST) begin
              cmd_state <= CMD_READ;
            end else begin
              cmd_state <= CMD_WRITE;
            end
          end
        end
        CMD_READ: begin
          cnt <= cnt + 7'h01;
          if ({9'h000, cnt} + 16'h0001 == list_word_count) begin
            cmd_state  <= CMD_IDLE;
            O_CMD_DONE <= 1'b1;
          end
        end
        CMD_WRITE: begin
          if (I_WR_VALID) begin
            cnt <= cnt + 7'h01;
            if ({9'h000, cnt} + 16'h0001 == list_word_count) begin
              cmd_state  <= CMD_IDLE;
              O_CMD_DONE <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Read data leaves a flop, so each word follows its index by one cycle.
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_RD_VALID <= 1'b0;
      O_RD_WORD  <= 16'h0000;
    end else begin
      O_RD_VALID <= (cmd_state == CMD_READ);
      O_RD_WORD  <= (cmd_state == CMD_READ) ? host_word : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host-writable fields.

  // Writes to fixed, verification or undefined words are dropped silently.
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      requested_software_kind <= sysid_pkg::SOFT_KIND_RST;
      char_count_field        <= sysid_pkg::CHAR_BASE;
    end else if ((cmd_state == CMD_WRITE) && I_WR_VALID) begin
      if (cnt == sysid_pkg::IDX_SOFT_KIND) begin
        requested_software_kind <= I_WR_WORD[7:0];
      end
      if (cnt == sysid_pkg::IDX_CHAR_COUNT) begin
        char_count_field <= I_WR_WORD;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      for (int i = 0; i < sysid_pkg::EXTRA_WORDS; i++) begin
        extra_info_block[i] <= 16'h0000;
      end
    end else if ((cmd_state == CMD_WRITE) && I_WR_VALID && (cnt >= sysid_pkg::IDX_EXTRA_BASE)) begin
      extra_info_block[cnt - sysid_pkg::IDX_EXTRA_BASE] <= I_WR_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Program request on a boot command.

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_PROG_REQ                <= 1'b0;
      O_REQUESTED_SOFTWARE_KIND <= 8'h00;
    end else begin
      O_PROG_REQ <= I_BOOT_CMD;
      if (I_BOOT_CMD) begin
        O_REQUESTED_SOFTWARE_KIND <= requested_software_kind;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Identification frame byte stream.

  // A count below the fixed part gives no extras; above the area it is capped.
  always_comb begin
    if (char_count_field <= sysid_pkg::CHAR_BASE) begin
      extra_bytes = 8'h00;
    end else if (char_count_field - sysid_pkg::CHAR_BASE >= {8'h00, sysid_pkg::EXTRA_MAX_BYTES}) begin
      extra_bytes = sysid_pkg::EXTRA_MAX_BYTES;
    end else begin
      extra_bytes = 8'(char_count_field - sysid_pkg::CHAR_BASE);
    end
  end

  // Fixed words run from the message type on; extras follow the device code.
  always_comb begin
    if (tx_pos < sysid_pkg::FIXED_BYTES) begin
      tx_idx = sysid_pkg::IDX_MSG_TYPE + 7'(tx_pos[7:1]);
    end else begin
      tx_idx = sysid_pkg::IDX_EXTRA_BASE + 7'(tx_pos[7:1] - sysid_pkg::FIXED_BYTES[7:1]);
    end
  end

  assign rom_if.tx_idx = tx_idx;

  always_comb begin
    tx_word = list_word(tx_idx, rom_if.tx_word);
    if (tx_idx == sysid_pkg::IDX_RECEIPT) begin
      tx_word = receipt_number;
    end
  end

  assign tx_take      = (tx_state != TX_IDLE) && (!O_TX_VALID || I_TX_READY);
  assign O_FRAME_BUSY = (tx_state != TX_IDLE) || O_TX_VALID;

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      tx_state       <= TX_IDLE;
      tx_pos         <= 8'h00;
      tx_total       <= 8'h00;
      receipt_number <= sysid_pkg::RECEIPT_NORMAL;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          tx_pos <= 8'h00;
          if (I_FRAME_START && !O_TX_VALID) begin
            tx_state       <= TX_FIXED;
            tx_total       <= sysid_pkg::FIXED_BYTES + extra_bytes;
            receipt_number <= I_FRAME_IS_REPLY ? I_REQ_RECEIPT_NUMBER : sysid_pkg::RECEIPT_NORMAL;
          end
        end
        TX_FIXED, TX_EXTRA: begin
          if (tx_take) begin
            tx_pos <= tx_pos + 8'h01;
            if (tx_pos + 8'h01 == tx_total) begin
              tx_state <= TX_IDLE;
            end else if (tx_pos + 8'h01 == sysid_pkg::FIXED_BYTES) begin
              tx_state <= TX_EXTRA;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_TX_VALID <= 1'b0;
      O_TX_DATA  <= 8'h00;
      O_TX_LAST  <= 1'b0;
    end else if (tx_take) begin
      O_TX_VALID <= 1'b1;
      O_TX_DATA  <= tx_pos[0] ? tx_word[15:8] : tx_word[7:0];
      O_TX_LAST  <= (tx_pos + 8'h01 == tx_total);
    end else if (I_TX_READY) begin
      O_TX_VALID <= 1'b0;
      O_TX_LAST  <= 1'b0;
    end
  end

  // Unused upper part of the stored count only limits the extras above.
  initial begin
    if (sysid_pkg::LIST_WORDS != int'(sysid_pkg::IDX_EXTRA_BASE) + sysid_pkg::EXTRA_WORDS) begin
      $error("List layout does not add up.");
    end
  end

  // The device code word carries the model byte in its high half.
  initial begin
    if (DEVICE_CODE == 8'h00) begin
      $error("Device code must be nonzero.");
    end
  end

endmodule : sysid_frame_builder
`default_nettype wire

// ### shared/sysid_pkg.sv
// Constants for the station identification parameter block and frame.
`default_nettype none
package sysid_pkg;
  localparam logic [7:0]  OP_READ_LIST   = 8'h16;
  localparam logic [7:0]  OP_WRITE_LIST  = 8'h17;
  localparam logic [15:0] LIST_MAX_WORDS = 16'h0064;
  localparam int          LIST_WORDS     = 100;
  localparam logic [6:0]  IDX_SOFT_KIND  = 7'h04;
  localparam logic [6:0]  IDX_MSG_TYPE   = 7'h0B;
  localparam logic [6:0]  IDX_CHAR_COUNT = 7'h0C;
  localparam logic [6:0]  IDX_CODE       = 7'h0D;
  localparam logic [6:0]  IDX_RECEIPT    = 7'h0E;
  localparam logic [6:0]  IDX_PV_KIND    = 7'h0F;
  localparam logic [6:0]  IDX_PV_NUMBER  = 7'h10;
  localparam logic [6:0]  IDX_PV_CHANGE  = 7'h11;
  localparam logic [6:0]  IDX_FUNC_KIND  = 7'h12;
  localparam logic [6:0]  IDX_FUNC_ONE   = 7'h13;
  localparam logic [6:0]  IDX_FUNC_TWO   = 7'h14;
  localparam logic [6:0]  IDX_ADDR_SIZE  = 7'h15;
  localparam logic [6:0]  IDX_ADDR_LOW   = 7'h16;
  localparam logic [6:0]  IDX_ADDR_MID   = 7'h17;
  localparam logic [6:0]  IDX_ADDR_HIGH  = 7'h18;
  localparam logic [6:0]  IDX_DEV_KIND   = 7'h19;
  localparam logic [6:0]  IDX_DEV_CODE   = 7'h1A;
  localparam logic [6:0]  IDX_EXTRA_BASE = 7'h1B;
  localparam int          EXTRA_WORDS    = 73;
  localparam logic [7:0]  EXTRA_MAX_BYTES = 8'h92;
  localparam logic [7:0]  FIXED_BYTES    = 8'h20;
  localparam logic [15:0] CHAR_BASE      = 16'h001C;
  localparam logic [15:0] MSG_TYPE_VAL   = 16'h0260;
  localparam logic [7:0]  CODE_VAL       = 8'h07;
  localparam logic [15:0] PV_KIND_VAL    = 16'h0001;
  localparam logic [7:0]  PV_SIZE_VAL    = 8'h03;
  localparam logic [7:0]  PV_NUMBER_VAL  = 8'h03;
  localparam logic [7:0]  PV_CHANGE_VAL  = 8'h00;
  localparam logic [7:0]  PV_USER_VAL    = 8'h00;
  localparam logic [15:0] FUNC_KIND_VAL  = 16'h0002;
  localparam logic [7:0]  FUNC_SIZE_VAL  = 8'h02;
  localparam logic [7:0]  FUNC_ONE_BOOT  = 8'h15;
  localparam logic [7:0]  FUNC_ONE_NOBOOT = 8'h05;
  localparam logic [7:0]  FUNC_TWO_VAL   = 8'h00;
  localparam logic [7:0]  ADDR_KIND_LO   = 8'h07;
  localparam logic [7:0]  ADDR_KIND_HI   = 8'h00;
  localparam logic [7:0]  ADDR_SIZE_VAL  = 8'h06;
  localparam logic [15:0] DEV_KIND_VAL   = 16'h0064;
  localparam logic [7:0]  DEV_SIZE_VAL   = 8'h01;
  localparam logic [15:0] RECEIPT_NORMAL = 16'h0000;
  localparam logic [7:0]  SOFT_KIND_RST  = 8'h00;
endpackage : sysid_pkg
`default_nettype wire

// ### shared/sysid_rom_if.sv
// Lookup channel between the builder and its read-only field table.
`default_nettype none
interface sysid_rom_if;
  logic [6:0]  host_idx;
  logic [15:0] host_word;
  logic [6:0]  tx_idx;
  logic [15:0] tx_word;
  logic        remote_boot;
  modport user (output host_idx, output tx_idx, output remote_boot, input host_word, input tx_word);
  modport rom  (input host_idx, input tx_idx, input remote_boot, output host_word, output tx_word);
endinterface : sysid_rom_if
`default_nettype wire

// ### design/sysid_fixed_rom.sv
// Read-only identification fields, looked up by data block word index.
`default_nettype none
module sysid_fixed_rom #(
  parameter logic [47:0] STATION_ADDR = 48'h0000_0000_0000,
  parameter logic [7:0]  DEVICE_CODE  = 8'h5A
) (
  sysid_rom_if.rom rom
);

  function automatic logic [15:0] fixed_word(input logic [6:0] idx, input logic boot_on);
    logic [15:0] w;
    w = 16'h0000;
    unique case (idx)
      sysid_pkg::IDX_MSG_TYPE:   w = sysid_pkg::MSG_TYPE_VAL;
      sysid_pkg::IDX_CODE:       w = {8'h00, sysid_pkg::CODE_VAL};
      sysid_pkg::IDX_RECEIPT:    w = sysid_pkg::RECEIPT_NORMAL;
      sysid_pkg::IDX_PV_KIND:    w = sysid_pkg::PV_KIND_VAL;
      sysid_pkg::IDX_PV_NUMBER:  w = {sysid_pkg::PV_NUMBER_VAL, sysid_pkg::PV_SIZE_VAL};
      sysid_pkg::IDX_PV_CHANGE:  w = {sysid_pkg::PV_USER_VAL, sysid_pkg::PV_CHANGE_VAL};
      sysid_pkg::IDX_FUNC_KIND:  w = sysid_pkg::FUNC_KIND_VAL;
      sysid_pkg::IDX_FUNC_ONE:   w = {boot_on ? sysid_pkg::FUNC_ONE_BOOT : sysid_pkg::FUNC_ONE_NOBOOT,
                                      sysid_pkg::FUNC_SIZE_VAL};
      sysid_pkg::IDX_FUNC_TWO:   w = {sysid_pkg::ADDR_KIND_LO, sysid_pkg::FUNC_TWO_VAL};
      sysid_pkg::IDX_ADDR_SIZE:  w = {sysid_pkg::ADDR_SIZE_VAL, sysid_pkg::ADDR_KIND_HI};
      sysid_pkg::IDX_ADDR_LOW:   w = STATION_ADDR[15:0];
      sysid_pkg::IDX_ADDR_MID:   w = STATION_ADDR[31:16];
      sysid_pkg::IDX_ADDR_HIGH:  w = STATION_ADDR[47:32];
      sysid_pkg::IDX_DEV_KIND:   w = sysid_pkg::DEV_KIND_VAL;
      sysid_pkg::IDX_DEV_CODE:   w = {DEVICE_CODE, sysid_pkg::DEV_SIZE_VAL};
      default:                   w = 16'h0000;
    endcase
    return w;
  endfunction : fixed_word

  assign rom.host_word = fixed_word(rom.host_idx, rom.remote_boot);
  assign rom.tx_word   = fixed_word(rom.tx_idx, rom.remote_boot);

endmodule : sysid_fixed_rom
`default_nettype wire

// ### dv/sysid_frame_builder_sva.sv
// Concurrent checks on the identification frame builder ports.
`default_nettype none
module sysid_frame_builder_sva (
  input wire logic        I_CLOCK,
  input wire logic        I_SRST,
  input wire logic        I_CMD_VALID,
  input wire logic [7:0]  I_CMD_OPCODE,
  input wire logic [15:0] I_LIST_WORD_COUNT,
  input wire logic        O_CMD_BUSY,
  input wire logic        O_CMD_DONE,
  input wire logic        O_CMD_ERROR,
  input wire logic        O_RD_VALID,
  input wire logic        I_BOOT_CMD,
  input wire logic        O_PROG_REQ,
  input wire logic        I_FRAME_START,
  input wire logic        O_FRAME_BUSY,
  input wire logic        O_TX_VALID,
  input wire logic [7:0]  O_TX_DATA,
  input wire logic        O_TX_LAST,
  input wire logic        I_TX_READY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);
  ////////////////////////////////////////////////////////////
  logic take;
  assign take = I_CMD_VALID && !O_CMD_BUSY;
  sequence s_frame_go;
    I_FRAME_START && !O_FRAME_BUSY;
  endsequence
  sequence s_first_out;
    ##2 (O_TX_VALID && O_TX_DATA == 8'h60);
  endsequence
  chk_len_abort: assert property (take && I_LIST_WORD_COUNT > 16'h0064
    |=> O_CMD_DONE && O_CMD_ERROR && !O_RD_VALID) else $error("over-long list not aborted");
  chk_bad_opcode: assert property (take && I_CMD_OPCODE != 8'h16 && I_CMD_OPCODE != 8'h17
    |=> O_CMD_DONE && O_CMD_ERROR) else $error("unknown opcode not refused");
  chk_read_start: assert property (take && I_CMD_OPCODE == 8'h16 && I_LIST_WORD_COUNT inside {[16'h0001:16'h0064]}
    |=> !O_CMD_ERROR ##1 O_RD_VALID) else $error("read list did not start");
  chk_write_ok: assert property (take && I_CMD_OPCODE == 8'h17 && I_LIST_WORD_COUNT <= 16'h0064
    |=> !O_CMD_ERROR) else $error("legal write refused");
  chk_error_done: assert property (O_CMD_ERROR |-> O_CMD_DONE) else $error("error without done");
  chk_prog_req: assert property (I_BOOT_CMD |=> O_PROG_REQ) else $error("boot gave no program request");
  chk_first_byte: assert property (s_frame_go |-> s_first_out) else $error("frame does not open with 60h");
  chk_second_byte: assert property (s_frame_go ##2 (O_TX_VALID && I_TX_READY)
    |=> O_TX_VALID && O_TX_DATA == 8'h02) else $error("second frame byte not 02h");
  chk_byte_hold: assert property (O_TX_VALID && !I_TX_READY
    |=> O_TX_VALID && $stable(O_TX_DATA) && $stable(O_TX_LAST)) else $error("stalled byte changed");
  chk_busy_release: assert property (O_TX_LAST && I_TX_READY |=> !O_FRAME_BUSY) else $error("busy after end");
  chk_last_valid: assert property (O_TX_LAST |-> O_TX_VALID) else $error("last flag without byte");
endmodule : sysid_frame_builder_sva
bind sysid_frame_builder sysid_frame_builder_sva sysid_frame_builder_sva_i (
  .I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_CMD_VALID(I_CMD_VALID), .I_CMD_OPCODE(I_CMD_OPCODE),
  .I_LIST_WORD_COUNT(I_LIST_WORD_COUNT), .O_CMD_BUSY(O_CMD_BUSY), .O_CMD_DONE(O_CMD_DONE),
  .O_CMD_ERROR(O_CMD_ERROR), .O_RD_VALID(O_RD_VALID), .I_BOOT_CMD(I_BOOT_CMD), .O_PROG_REQ(O_PROG_REQ),
  .I_FRAME_START(I_FRAME_START), .O_FRAME_BUSY(O_FRAME_BUSY), .O_TX_VALID(O_TX_VALID),
  .O_TX_DATA(O_TX_DATA), .O_TX_LAST(O_TX_LAST), .I_TX_READY(I_TX_READY));
`default_nettype wire

// ### dv/sysid_net_partner.sv
// Network node model that asks for identification frames and takes their bytes.
`default_nettype none
module sysid_net_partner (
  input  wire logic       clk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            start,
  output logic            is_reply,
  output logic [15:0]     receipt,
  output logic            ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  int         last_at;
  int         cyc;
  bit         stall;
  ////////////////////////////////////////////////////////////
  initial begin
    start = 1'b0;
    is_reply = 1'b0;
    receipt = 16'hFFFF;
    ready = 1'b1;
    cyc = 0;
  end
  // A slow node drops ready every third cycle so the stall path is exercised.
  always @(negedge clk) begin
    cyc++;
    ready <= !stall || (cyc % 3 != 0);
  end
  always @(posedge clk) begin
    if (tx_valid && ready) begin
      got.push_back(tx_data);
      if (tx_last) last_at = got.size();
    end
  end
  // Outside the start pulse the receipt lines show garbage, not the last value.
  task automatic send(input logic r, input logic [15:0] n);
    @(negedge clk);
    start = 1'b1;
    is_reply = r;
    receipt = n;
    @(negedge clk);
    start = 1'b0;
    is_reply = ~r;
    receipt = ~n;
  endtask : send
endmodule : sysid_net_partner
`default_nettype wire

// ### dv/sysid_frame_builder_tb_top.sv
// Self-checking bench for the identification frame builder.
`default_nettype none
module sysid_frame_builder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary device code, chosen apart from every fixed field byte.
  localparam logic [7:0]  DEV_CODE = 8'h3C;
  localparam logic [47:0] ADDR     = 48'h0A0B_0C0D_0E0F;
  logic        clk, srst, cmd_valid, wr_valid, boot_sw, boot_cmd;
  logic [7:0]  cmd_op, req_kind, tx_data, kind;
  logic [15:0] cmd_len, wr_word, rd_word, receipt, cc, e0, e1, rcpt;
  logic        cmd_busy, cmd_done, cmd_error, rd_valid, prog_req, start, is_reply;
  logic        frame_busy, tx_valid, tx_last, ready;
  logic [15:0] wq[$];
  logic [7:0]  bad_op[4]  = '{8'h16, 8'h17, 8'h18, 8'h00};
  logic [15:0] bad_len[4] = '{16'h0065, 16'h0065, 16'h0001, 16'h0001};
  int          fail_count;
  int          n_compared;
  ////////////////////////////////////////////////////////////
  sysid_frame_builder #(.STATION_ADDR(ADDR), .DEVICE_CODE(DEV_CODE)) sysid_frame_builder_i (
    .I_CLOCK(clk), .I_SRST(srst), .I_CMD_VALID(cmd_valid), .I_CMD_OPCODE(cmd_op),
    .I_LIST_WORD_COUNT(cmd_len), .O_CMD_BUSY(cmd_busy), .O_CMD_DONE(cmd_done), .O_CMD_ERROR(cmd_error),
    .I_WR_VALID(wr_valid), .I_WR_WORD(wr_word), .O_RD_VALID(rd_valid), .O_RD_WORD(rd_word),
    .I_REMOTE_BOOT_SW(boot_sw), .I_BOOT_CMD(boot_cmd), .O_PROG_REQ(prog_req),
    .O_REQUESTED_SOFTWARE_KIND(req_kind), .I_FRAME_START(start), .I_FRAME_IS_REPLY(is_reply),
    .I_REQ_RECEIPT_NUMBER(receipt), .O_FRAME_BUSY(frame_busy), .O_TX_VALID(tx_valid),
    .O_TX_DATA(tx_data), .O_TX_LAST(tx_last), .I_TX_READY(ready));
  sysid_net_partner sysid_net_partner_i (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .start(start), .is_reply(is_reply), .receipt(receipt), .ready(ready));
  function automatic logic [15:0] expw(input int k);
    case (k)
      4: return {8'h00, kind};
      11: return 16'h0260;
      12: return cc;
      13: return 16'h0007;
      15: return 16'h0001;
      16: return 16'h0303;
      18: return 16'h0002;
      19: return {boot_sw ? 8'h15 : 8'h05, 8'h02};
      20: return 16'h0700;
      21: return 16'h0600;
      22: return ADDR[15:0];
      23: return ADDR[31:16];
      24: return ADDR[47:32];
      25: return 16'h0064;
      26: return {DEV_CODE, 8'h01};
      27: return e0;
      28: return e1;
      default: return 16'h0000;
    endcase
  endfunction : expw
  function automatic logic [7:0] fb(input int i);
    logic [15:0] w;
    w = (i < 32) ? (i / 2 == 3 ? rcpt : expw(11 + i / 2)) : expw(27 + (i - 32) / 2);
    return i[0] ? w[15:8] : w[7:0];
  endfunction : fb
  task automatic cmpw(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : cmpw
  task automatic cmpb(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask : cmpb
  task automatic cmd(input logic [7:0] op, input logic [15:0] n);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_len = n;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : cmd
  task automatic wait_done(input logic err);
    int g;
    g = 0;
    while (cmd_done !== 1'b1 && g < 20) begin
      @(negedge clk);
      g++;
    end
    cmpb("command done", 1'b1, cmd_done);
    cmpb("command error", err, cmd_error);
  endtask : wait_done
  task automatic rd_list(input logic [15:0] n);
    int k;
    int g;
    k = 0;
    g = 0;
    cmd(8'h16, n);
    while (k < n && g < 300) begin
      @(negedge clk);
      g++;
      if (rd_valid === 1'b1) begin
        cmpw("read word", expw(k), rd_word);
        if (k == n - 1) cmpb("read done", 1'b1, cmd_done);
        k++;
      end
    end
    cmpw("read count", n, 16'(k));
  endtask : rd_list
  task automatic wr_list();
    cmd(8'h17, 16'(wq.size()));
    foreach (wq[k]) begin
      wr_valid = 1'b1;
      wr_word = wq[k];
      @(negedge clk);
    end
    wr_valid = 1'b0;
    wait_done(1'b0);
  endtask : wr_list
  task automatic frame(input logic r, input logic [15:0] n, input logic st, input int len);
    int g;
    g = 0;
    rcpt = r ? n : 16'h0000;
    sysid_net_partner_i.stall = st;
    sysid_net_partner_i.got.delete();
    sysid_net_partner_i.last_at = 0;
    sysid_net_partner_i.send(r, n);
    while (sysid_net_partner_i.last_at == 0 && g < 400) begin
      @(negedge clk);
      g++;
    end
    repeat (3) @(negedge clk);
    cmpw("frame length", 16'(len), 16'(sysid_net_partner_i.got.size()));
    cmpw("last position", 16'(len), 16'(sysid_net_partner_i.last_at));
    for (int i = 0; i < len; i++) cmpw("frame byte", {8'h00, fb(i)}, {8'h00, sysid_net_partner_i.got[i]});
  endtask : frame
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles; this only catches a hang.
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    {srst, cmd_valid, wr_valid, boot_sw, boot_cmd} = 5'b10000;
    {cmd_op, cmd_len, wr_word} = 40'h00_0000_0000;
    {fail_count, n_compared} = 64'h0;
    {kind, cc, e0, e1, rcpt} = 72'h00_001C_0000_0000_0000;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    rd_list(16'h001B);
    frame(1'b0, 16'h5A5A, 1'b0, 32);
    for (int k = 0; k < 29; k++) wq.push_back(16'hFFFF);
    wq[4] = 16'h00A5;
    wq[12] = 16'h0020;
    wq[27] = 16'hBEEF;
    wq[28] = 16'h1234;
    wr_list();
    {kind, cc, e0, e1} = 56'hA5_0020_BEEF_1234;
    rd_list(16'h0064);
    @(negedge clk);
    boot_cmd = 1'b1;
    @(negedge clk);
    boot_cmd = 1'b0;
    cmpb("program request", 1'b1, prog_req);
    cmpw("software kind", {8'h00, kind}, {8'h00, req_kind});
    foreach (bad_op[i]) begin
      cmd(bad_op[i], bad_len[i]);
      wait_done(1'b1);
    end
    boot_sw = 1'b1;
    repeat (6) @(negedge clk);
    frame(1'b1, 16'hBEAD, 1'b1, 36);
    rd_list(16'h001D);
    end_of_test();
  end
endmodule : sysid_frame_builder_tb_top
`default_nettype wire
